// ===== design/asc_defines.vh
// Constants for the asynchronous SRAM bus controller.
// Assumes a 125 MHz mclk; times are in ns, counts derived from them.
`ifndef ASC_DEFINES_VH
`define ASC_DEFINES_VH

`define ASC_CLK_NS 8
`define ASC_ADDR_W 15
`define ASC_DATA_W 8
// Write pulse width, minimum
`define ASC_T_WP_NS 15
// Write to float delay, maximum
`define ASC_T_WHZ_NS 10
// Data overlap time, minimum
`define ASC_T_DW_NS 8
// Read cycle / access time
`define ASC_T_RC_NS 20
// Output disable to float, maximum
`define ASC_T_OHZ_NS 8
// Round up to whole cycles; zero ns gives zero cycles
`define ASC_CYC(ns) (((ns) + `ASC_CLK_NS - 1) / `ASC_CLK_NS)
`define ASC_CNT_W 4
// Cycle from the address to the select edge in a read
`define ASC_SETUP_CYC 1
// Flops that the sensed data bus passes
`define ASC_SYNC_CYC 2
`define ASC_ONE 4'h1

`endif

// ===== design/asc_timer.v
// Down-counter that paces each bus phase of the SRAM controller.
// Assumes load and the count come from logic on the same mclk.
`timescale 1ns/10ps
module asc_timer #(
    parameter CNT_W = 4
) (
    input wire mclk,              // System clock
    input wire reset_n,           // Async reset, active low
    input wire load,              // Start a new phase
    input wire [CNT_W-1:0] cycles, // Phase length in cycles
    output reg done               // Phase over, level
);
reg [CNT_W-1:0] cnt_q;

always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        cnt_q <= {CNT_W{1'b0}};
        done <= 1'b1;
    end else if (load) begin
        cnt_q <= cycles - 1'b1;
        done <= (cycles <= 1);
    end else if (cnt_q != {CNT_W{1'b0}}) begin
        cnt_q <= cnt_q - 1'b1;
        done <= (cnt_q == 1);
    end
end
endmodule

// ===== design/asc_ctrl.v
// Host-side controller for an asynchronous 32K x 8 static RAM.
// Assumes the SRAM pins are joined by the bench; data bus is split
// into in, out and enable. User requests come from mclk logic.
`timescale 1ns/10ps
`include "asc_defines.vh"

////////////////////////////////////////////////////////////////////////
module asc_ctrl #(
    parameter ADDR_W = `ASC_ADDR_W,
    parameter DATA_W = `ASC_DATA_W
) (
    input wire mclk,                   // System clock, 125 MHz
    input wire reset_n,                // Async reset, active low
    input wire req_valid,              // Request, level until accepted
    input wire req_write,              // 1 write, 0 read
    input wire [ADDR_W-1:0] req_addr,  // Byte address
    input wire [DATA_W-1:0] req_wdata, // Write byte
    output reg req_ready,              // Idle, request taken when high
    output reg rsp_valid,              // Read data valid, one pulse
    output reg [DATA_W-1:0] rsp_rdata, // Read byte
    output reg wr_done,                // Write finished, one pulse
    output reg [ADDR_W-1:0] address_lines, // SRAM address
    output reg chip_sel_n,             // SRAM chip select, active low
    output reg write_en_n,             // SRAM write enable, active low
    output reg out_en_n,               // SRAM output enable, active low
    input wire [DATA_W-1:0] data_bus_pins_in, // Data bus sensed
    output reg [DATA_W-1:0] data_bus_pins_out, // Data bus driven
    output reg data_bus_pins_oe        // High while driving the bus
);

////////////////////////////////////////////////////////////////////////
// Cycle count to timer width; saturates so a slow part never wraps
// round to a short phase
function [`ASC_CNT_W-1:0] cyc_to_len;
    input integer n;
    begin
        if (n >= (1 << `ASC_CNT_W)) begin
            cyc_to_len = {`ASC_CNT_W{1'b1}};
        end else begin
            cyc_to_len = n[`ASC_CNT_W-1:0];
        end
    end
endfunction

localparam WP_CYC = `ASC_CYC(`ASC_T_WP_NS);
localparam OVL_CYC = `ASC_CYC(`ASC_T_WHZ_NS + `ASC_T_DW_NS);
// Pulse kept long enough even if OE were low, safe either way
localparam WR_CYC = (WP_CYC > OVL_CYC) ? WP_CYC : OVL_CYC;
localparam RD_CYC = `ASC_CYC(`ASC_T_RC_NS);
// Select falls a cycle after the take; the bus is sampled once the
// access time has run, then crosses the two sync flops
localparam RD_TOT = `ASC_SETUP_CYC + RD_CYC + `ASC_SYNC_CYC;
localparam HZ_CYC = `ASC_CYC(`ASC_T_OHZ_NS);
localparam [`ASC_CNT_W-1:0] WR_LEN = cyc_to_len(WR_CYC);
localparam [`ASC_CNT_W-1:0] RD_LEN = cyc_to_len(RD_TOT);
localparam [`ASC_CNT_W-1:0] HZ_LEN = cyc_to_len(HZ_CYC);

localparam S_IDLE = 3'd0;
localparam S_SETUP = 3'd1;
localparam S_WPULSE = 3'd2;
localparam S_WREC = 3'd3;
localparam S_READ = 3'd4;
localparam S_RFLOAT = 3'd5;

reg [2:0] state_q;
reg [2:0] state_d;
reg load;
reg [`ASC_CNT_W-1:0] cycles;
reg [DATA_W-1:0] rd_s1_d_q;
reg [DATA_W-1:0] rd_s2_q;
wire done;

asc_timer #(.CNT_W(`ASC_CNT_W)) u_timer (
    .mclk(mclk),
    .reset_n(reset_n),
    .load(load),
    .cycles(cycles),
    .done(done)
);

////////////////////////////////////////////////////////////////////////
// Read data passes two flops, it is asynchronous to mclk
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        rd_s1_d_q <= {DATA_W{1'b0}};
        rd_s2_q <= {DATA_W{1'b0}};
    end else begin
        rd_s1_d_q <= data_bus_pins_in;
        rd_s2_q <= rd_s1_d_q;
    end
end

////////////////////////////////////////////////////////////////////////
always @* begin
    state_d = state_q;
    load = 1'b0;
    cycles = `ASC_ONE;
    case (state_q)
    S_IDLE: begin
        if (req_valid && req_write) begin
            state_d = S_SETUP;
            load = 1'b1;
        end else if (req_valid) begin
            state_d = S_READ;
            load = 1'b1;
            cycles = RD_LEN;
        end
    end
    S_SETUP: begin
        state_d = S_WPULSE;
        load = 1'b1;
        cycles = WR_LEN;
    end
    S_WPULSE: begin
        if (done) begin
            state_d = S_WREC;
            load = 1'b1;
        end
    end
    S_WREC: begin
        if (done) begin
            state_d = S_IDLE;
        end
    end
    S_READ: begin
        if (done) begin
            state_d = S_RFLOAT;
            load = 1'b1;
            cycles = HZ_LEN;
        end
    end
    S_RFLOAT: begin
        if (done) begin
            state_d = S_IDLE;
        end
    end
    default: begin
        state_d = S_IDLE;
    end
    endcase
end

////////////////////////////////////////////////////////////////////////
always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
        state_q <= S_IDLE;
        req_ready <= 1'b1;
        rsp_valid <= 1'b0;
        rsp_rdata <= {DATA_W{1'b0}};
        wr_done <= 1'b0;
        address_lines <= {ADDR_W{1'b0}};
        chip_sel_n <= 1'b1;
        write_en_n <= 1'b1;
        out_en_n <= 1'b1;
        data_bus_pins_out <= {DATA_W{1'b0}};
        data_bus_pins_oe <= 1'b0;
    end else begin
        state_q <= state_d;
        rsp_valid <= 1'b0;
        wr_done <= 1'b0;
        req_ready <= (state_d == S_IDLE);
        case (state_d)
        S_SETUP: begin
            // Address set while both strobes high, OE held high
            address_lines <= req_addr;
            data_bus_pins_out <= req_wdata;
            out_en_n <= 1'b1;
        end
        S_WPULSE: begin
            // Select and write enable fall together: SRAM stays floating
            chip_sel_n <= 1'b0;
            write_en_n <= 1'b0;
            data_bus_pins_oe <= 1'b1;
        end
        S_WREC: begin
            // Both rise together; data held one cycle past the edge
            chip_sel_n <= 1'b1;
            write_en_n <= 1'b1;
        end
        S_READ: begin
            if (state_q == S_IDLE) begin
                // Address settles before select falls
                address_lines <= req_addr;
            end else begin
                chip_sel_n <= 1'b0;
                out_en_n <= 1'b0;
            end
            write_en_n <= 1'b1;
            data_bus_pins_oe <= 1'b0;
        end
        S_RFLOAT: begin
            // Leave a float gap so a following write finds a quiet bus
            chip_sel_n <= 1'b1;
            out_en_n <= 1'b1;
            if (state_q == S_READ) begin
                // Bus as it stood once the access time had run
                rsp_valid <= 1'b1;
                rsp_rdata <= rd_s2_q;
            end
        end
        default: begin
            chip_sel_n <= 1'b1;
            write_en_n <= 1'b1;
            data_bus_pins_oe <= 1'b0;
            if (state_q == S_WREC) begin
                wr_done <= 1'b1;
            end
        end
        endcase
    end
end
endmodule

// ===== testbench/asc_properties.sv
// Pin-sequencing checks for asc_ctrl.
// Assumes a bind to asc_ctrl; one mclk domain.
`timescale 1ns/10ps
module asc_properties (
    input wire mclk, // Clock
    input wire reset_n, // Reset
    input wire req_valid, // Request
    input wire req_write, // Write
    input wire req_ready, // Idle
    input wire rsp_valid, // Read done
    input wire wr_done, // Write done
    input wire [14:0] address_lines, // Address
    input wire chip_sel_n, // Select
    input wire write_en_n, // Write strobe
    input wire out_en_n, // Output enable
    input wire data_bus_pins_oe // Host drives
);
default clocking @(posedge mclk); endclocking
default disable iff (!reset_n);
wire wr_on = !chip_sel_n && !write_en_n;
wire take = req_valid && req_ready;
chk_addr_hold: assert property (wr_on && $past(wr_on) |->
    $stable(address_lines)) else $error("address moved in write");
chk_read_we: assert property (!out_en_n |-> write_en_n)
    else $error("write strobe low in read");
chk_no_clash: assert property (data_bus_pins_oe |->
    out_en_n && $past(out_en_n)) else $error("bus contention");
chk_pulse_len: assert property ($fell(write_en_n) |->
    !write_en_n [*3] ##1 write_en_n) else $error("write pulse length");
chk_data_drive: assert property (wr_on |-> data_bus_pins_oe)
    else $error("no data in write");
chk_cs_read: assert property ($fell(out_en_n) |->
    !chip_sel_n && $stable(address_lines)) else $error("read setup");
chk_wr_done: assert property (take && req_write |-> ##6 wr_done)
    else $error("write latency");
chk_rd_resp: assert property (take && !req_write |-> ##7 rsp_valid)
    else $error("read latency");
endmodule

// ===== testbench/asc_sram_model.sv
// Behavioural 32K x 8 asynchronous SRAM, bus resolved here.
// Assumes the host drives the bus only while host_oe is high.
`timescale 1ns/10ps
module asc_sram_model #(
    parameter ACC_NS = 20 // Access time, slowest grade
) (
    input wire [14:0] address_lines, // Address
    input wire chip_sel_n, // Select
    input wire write_en_n, // Write strobe
    input wire out_en_n, // Output enable
    input wire [7:0] host_data, // Host value
    input wire host_oe, // Host drives
    output reg [7:0] bus // Resolved bus
);
reg [7:0] mem [0:32767];
reg [7:0] rd_q = 8'h00;
reg [7:0] last_q = 8'h00;
wire wr_act = !chip_sel_n && !write_en_n;
wire rd_act = !chip_sel_n && write_en_n && !out_en_n;
// Store what the bus shows at the end of the overlap
always @(negedge wr_act) mem[address_lines] = bus;
always @(address_lines or rd_act) rd_q <= #ACC_NS mem[address_lines];
always @(negedge host_oe) last_q = host_data;
always @(negedge rd_act) last_q = rd_q;
// No pull: a released bus shows the inverse of its last value
always @* begin
    if (host_oe) bus = host_data;
    else if (rd_act) bus = rd_q;
    else bus = ~last_q;
end
endmodule

// ===== testbench/asc_ctrl_bench.sv
// Self-checking bench for asc_ctrl with the SRAM model.
// Assumes the controller, model and checker are compiled first.
`timescale 1ns/10ps
module asc_ctrl_bench;
reg mclk = 1'b0;
reg reset_n = 1'b0;
reg req_valid = 1'b0;
reg req_write = 1'b0;
reg [14:0] req_addr = 15'h0000;
reg [7:0] req_wdata = 8'h00;
wire req_ready, rsp_valid, wr_done, cs_n, we_n, oe_n, bus_oe;
wire [7:0] rsp_rdata, bus_out, bus;
wire [14:0] addr;
integer num_errors = 0;
integer checks_done = 0;
integer lat;
reg [7:0] got;
asc_ctrl u_asc_ctrl (.mclk(mclk), .reset_n(reset_n), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .wr_done(wr_done), .address_lines(addr), .chip_sel_n(cs_n),
    .write_en_n(we_n), .out_en_n(oe_n), .data_bus_pins_in(bus),
    .data_bus_pins_out(bus_out), .data_bus_pins_oe(bus_oe));
asc_sram_model u_asc_sram_model (.address_lines(addr), .chip_sel_n(cs_n),
    .write_en_n(we_n), .out_en_n(oe_n), .host_data(bus_out),
    .host_oe(bus_oe), .bus(bus));
initial forever #4 mclk = ~mclk;
////////////////////////////////////////////////////////////////////////
task check(input [31:0] g, input [31:0] e);
    begin
        checks_done = checks_done + 1;
        if (g !== e) begin
            num_errors = num_errors + 1;
            $display("Error %0t: got %h exp %h", $time, g, e);
        end
    end
endtask
task stop_test;
    begin
        $display("Checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    end
endtask
// Latency counted in edges after the take; got holds the pulse data
task xfer(input wr, input [14:0] a, input [7:0] d);
    integer n;
    begin
        @(posedge mclk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        @(negedge mclk);
        for (n = 0; n < 20 && req_ready !== 1'b1; n = n + 1) @(negedge mclk);
        check(req_ready, 1'b1);
        @(posedge mclk);
        req_valid <= 1'b0;
        for (lat = 1; lat < 20; lat = lat + 1) begin
            @(negedge mclk);
            if (we_n === 1'b0) got = bus_out;
            if ((wr ? wr_done : rsp_valid) === 1'b1) break;
        end
        if (!wr) got = rsp_rdata;
    end
endtask
////////////////////////////////////////////////////////////////////////
task t_idle;
    check({cs_n, we_n, oe_n, bus_oe, req_ready}, 5'h1d);
endtask
task t_wr_rd;
    integer i;
    reg [14:0] a;
    begin
        for (i = 0; i < 8; i = i + 1) begin
            a = {15{i[0]}} ^ (i[1] ? 15'h2aaa : 15'h0000);
            xfer(~i[2], a, 8'ha5 ^ i[1:0]);
            check(lat, i[2] ? 7 : 6);
            check(got, 8'ha5 ^ i[1:0]);
        end
    end
endtask
task t_overwrite;
    begin
        xfer(1'b1, 15'h1234, 8'h3c);
        xfer(1'b1, 15'h1234, 8'hc3);
        xfer(1'b0, 15'h1234, 8'h00);
        check(got, 8'hc3);
    end
endtask
task t_mid_reset;
    begin
        xfer(1'b0, 15'h2aaa, 8'h00);
        check(got, 8'ha7);
        // Write caught inside its pulse by the reset
        @(posedge mclk);
        req_valid <= 1'b1;
        req_write <= 1'b1;
        req_addr <= 15'h0100;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b0;
        req_valid <= 1'b0;
        @(negedge mclk);
        t_idle;
        @(posedge mclk);
        reset_n <= 1'b1;
        xfer(1'b0, 15'h7fff, 8'h00);
        check(got, 8'ha4);
    end
endtask
initial begin
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    @(negedge mclk);
    t_idle;
    t_wr_rd;
    t_overwrite;
    t_mid_reset;
    stop_test;
end
initial begin
    #20000;
    num_errors = num_errors + 1;
    stop_test;
end
endmodule
bind asc_ctrl asc_properties u_asc_properties (.mclk(mclk),
    .reset_n(reset_n), .req_valid(req_valid), .req_write(req_write),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .wr_done(wr_done),
    .address_lines(address_lines), .chip_sel_n(chip_sel_n),
    .write_en_n(write_en_n), .out_en_n(out_en_n),
    .data_bus_pins_oe(data_bus_pins_oe));
